// ==== verilog/pfa_map.vh ====
// Register offsets, field positions and reset values of the flow action comparator
`ifndef PFA_MAP_VH
`define PFA_MAP_VH
`define PFA_FLOWS 8
`define PFA_CHANS 2
`define PFA_FLOW_STRIDE 12'h020
`define PFA_OFS_PAT_LO 12'h000
`define PFA_OFS_PAT_HI 12'h004
`define PFA_OFS_RANGE 12'h008
`define PFA_OFS_ACT_A 12'h00c
`define PFA_OFS_ACT_B 12'h010
`define PFA_OFS_ACT_C 12'h014
`define PFA_OFS_MASK_LO 12'h100
`define PFA_OFS_MASK_HI 12'h104
`define PFA_OFS_COMMON 12'h108
`define PFA_OFS_STATUS 12'h10c
`define PFA_WM_RANGE 32'h011fffff
`define PFA_WM_ACT_A 32'h071fffff
`define PFA_WM_ACT_B 32'h0f0f3f3f
`define PFA_WM_ACT_C 32'h0000ffff
`define PFA_WM_COMMON 32'h00000007
`define PFA_RST_WORD 32'h00000000
`define PFA_RNG_LO 0
`define PFA_RNG_HI 8
`define PFA_RNG_PTR 16
`define PFA_RNG_EN 24
`define PFA_A_CMD 0
`define PFA_A_SAVE 4
`define PFA_A_ASYM_ADD 5
`define PFA_A_ASYM_SUB 6
`define PFA_A_FLAG_UPD 7
`define PFA_A_FLOW_EN 8
`define PFA_A_CHAN 9
`define PFA_A_GROUP 11
`define PFA_A_CF_PTR 16
`define PFA_A_FLAG_PTR 24
`define PFA_B_TS_PTR 0
`define PFA_B_ZERO_PTR 8
`define PFA_B_ZERO_CNT 16
`define PFA_B_RW_BYTES 24
`define PFA_C_RW_OFS 0
`define PFA_C_NEW_CF 8
`define PFA_CMD_NONE 4'h0
`define PFA_CMD_SUB 4'h1
`define PFA_CMD_CF_MINUS_LATENCY_PLUS_PATH 4'h2
`define PFA_CMD_ADD 4'h3
`define PFA_CMD_SUB_ADD 4'h4
`define PFA_CMD_STORE 4'h5
`define PFA_CMD_LEGACY 4'h6
`define PFA_CMD_NS 4'h7
`define PFA_CMD_NS_PEER 4'h8
`endif

// ==== verilog/pfa_comparator.v ====
// Flow action comparator: per-flow header match and action selection
//
// Added by the designer: the APB interface to the registers and the register addresses.
`include "pfa_map.vh"

module pfa_comparator #(
    parameter OAM_ENGINE = 1
) (
    input wire I_MCLK,
    input wire I_RSTN,
    input wire I_CE,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output reg O_PREADY,
    output reg O_PSLVERR,
    input wire I_HDR_VALID,
    input wire [255:0] I_HDR_BYTES,
    input wire I_HDR_OAM,
    input wire I_HDR_CHAN,
    input wire I_HDR_EGRESS,
    input wire [1:0] I_PRIOR_GROUP,
    input wire [7:0] I_HDR_START,
    output reg O_ACT_VALID,
    output reg O_ACT_HIT,
    output reg [2:0] O_ACT_FLOW,
    output reg [3:0] O_ACT_CMD,
    output reg [8:0] O_ACT_OP,
    output reg O_SAVE_TIME,
    output reg [4:0] O_CF_PTR,
    output reg [5:0] O_TS_PTR,
    output reg O_ASYM_ADD,
    output reg O_ASYM_SUB,
    output reg O_ZERO_EN,
    output reg [5:0] O_ZERO_PTR,
    output reg [3:0] O_ZERO_CNT,
    output reg [2:0] O_FLAG_PTR,
    output reg [7:0] O_FLAG_PKT_OFS,
    output reg O_FLAG_UPD,
    output reg [3:0] O_RW_BYTES,
    output reg [7:0] O_RW_OFS,
    output reg [7:0] O_NEW_CF_LOC,
    output reg O_CHKSUM_SEL,
    output reg [1:0] O_ADDR_SRC
);
    // Per-flow configuration words
    reg [31:0] pat_lo [0:`PFA_FLOWS-1];
    reg [31:0] pat_hi [0:`PFA_FLOWS-1];
    reg [31:0] rng [0:`PFA_FLOWS-1];
    reg [31:0] act_a [0:`PFA_FLOWS-1];
    reg [31:0] act_b [0:`PFA_FLOWS-1];
    reg [31:0] act_c [0:`PFA_FLOWS-1];
    // Common controls
    reg [31:0] mask_lo;
    reg [31:0] mask_hi;
    reg [31:0] common;
    reg [2:0] last_flow;
    reg last_hit;
    reg [15:0] hit_count;
    integer k;

    // Bus decode
    wire [2:0] flow_idx = I_PADDR[7:5];
    wire [4:0] word_ofs = I_PADDR[4:0];
    wire in_flows = (I_PADDR[11:8] == 4'h0) && (word_ofs <= 5'h14) && (I_PADDR[1:0] == 2'h0);
    wire in_common = (I_PADDR[11:4] == 8'h10) && (I_PADDR[1:0] == 2'h0);
    wire mapped = in_flows || in_common;
    wire access = I_PSEL && I_PENABLE && O_PREADY;
    wire do_write = access && I_PWRITE && mapped;

    // Read mux
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h00000000;
        if (in_flows) begin
            case (word_ofs)
                5'h00: next_rdata = pat_lo[flow_idx];
                5'h04: next_rdata = pat_hi[flow_idx];
                5'h08: next_rdata = rng[flow_idx];
                5'h0c: next_rdata = act_a[flow_idx];
                5'h10: next_rdata = act_b[flow_idx];
                5'h14: next_rdata = act_c[flow_idx];
                default: next_rdata = 32'h00000000;
            endcase
        end else if (in_common) begin
            case (I_PADDR)
                `PFA_OFS_MASK_LO: next_rdata = mask_lo;
                `PFA_OFS_MASK_HI: next_rdata = mask_hi;
                `PFA_OFS_COMMON: next_rdata = common;
                `PFA_OFS_STATUS: next_rdata = {hit_count, 7'h00, last_hit, 5'h00, last_flow};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    // One wait state: ready rises in the second access cycle
    always @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h00000000;
            O_PSLVERR <= 1'b0;
        end else if (I_CE) begin
            O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
            O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && !mapped;
            if (I_PSEL && I_PENABLE && !O_PREADY && !I_PWRITE) begin
                O_PRDATA <= next_rdata;
            end
        end
    end

    // Configuration writes
    always @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (k = 0; k < `PFA_FLOWS; k = k + 1) begin
                pat_lo[k] <= `PFA_RST_WORD;
                pat_hi[k] <= `PFA_RST_WORD;
                rng[k] <= `PFA_RST_WORD;
                act_a[k] <= `PFA_RST_WORD;
                act_b[k] <= `PFA_RST_WORD;
                act_c[k] <= `PFA_RST_WORD;
            end
            mask_lo <= `PFA_RST_WORD;
            mask_hi <= `PFA_RST_WORD;
            common <= `PFA_RST_WORD;
        end else if (I_CE && do_write) begin
            if (in_flows) begin
                case (word_ofs)
                    5'h00: pat_lo[flow_idx] <= I_PWDATA;
                    5'h04: pat_hi[flow_idx] <= I_PWDATA;
                    5'h08: rng[flow_idx] <= I_PWDATA & `PFA_WM_RANGE;
                    5'h0c: act_a[flow_idx] <= I_PWDATA & `PFA_WM_ACT_A;
                    5'h10: act_b[flow_idx] <= I_PWDATA & `PFA_WM_ACT_B;
                    5'h14: act_c[flow_idx] <= I_PWDATA & `PFA_WM_ACT_C;
                    default: ;
                endcase
            end else begin
                case (I_PADDR)
                    `PFA_OFS_MASK_LO: mask_lo <= I_PWDATA;
                    `PFA_OFS_MASK_HI: mask_hi <= I_PWDATA;
                    `PFA_OFS_COMMON: common <= I_PWDATA & `PFA_WM_COMMON;
                    default: ;
                endcase
            end
        end
    end

    // Header bytes used: eight for timing, four for OAM
    wire [63:0] hdr_word = I_HDR_BYTES[255:192];
    wire [63:0] len_mask = I_HDR_OAM ? 64'hffffffff00000000 : 64'hffffffffffffffff;
    wire [63:0] eff_mask = {mask_hi, mask_lo} & len_mask;

    // Per-flow match
    wire [`PFA_FLOWS-1:0] hit;
    genvar f;
    generate
        for (f = 0; f < `PFA_FLOWS; f = f + 1) begin : g_flow
            wire [63:0] diff = (hdr_word ^ {pat_hi[f], pat_lo[f]}) & eff_mask;
            wire [4:0] rptr = rng[f][`PFA_RNG_PTR +: 5];
            wire [255:0] shifted = I_HDR_BYTES << {rptr, 3'h0};
            wire [7:0] rbyte = shifted[255:248];
            wire rng_ok = !rng[f][`PFA_RNG_EN] ||
                ((rbyte >= rng[f][`PFA_RNG_LO +: 8]) &&
                 (rbyte <= rng[f][`PFA_RNG_HI +: 8]));
            wire [1:0] chans = act_a[f][`PFA_A_CHAN +: 2];
            wire chan_ok = chans[I_HDR_CHAN];
            wire [1:0] grp = act_a[f][`PFA_A_GROUP +: 2];
            wire grp_ok = (OAM_ENGINE == 0) || (|(grp & I_PRIOR_GROUP));
            wire en = act_a[f][`PFA_A_FLOW_EN];
            assign hit[f] = !(|diff) && rng_ok && chan_ok && grp_ok && en;
        end
    endgenerate

    // Lowest numbered matching flow wins
    reg [2:0] sel;
    reg any;
    always @* begin
        sel = 3'h0;
        any = 1'b0;
        for (k = `PFA_FLOWS - 1; k >= 0; k = k - 1) begin
            if (hit[k]) begin
                sel = k[2:0];
                any = 1'b1;
            end
        end
    end

    wire [31:0] sa = act_a[sel];
    wire [31:0] sb = act_b[sel];
    wire [31:0] sc = act_c[sel];
    wire [3:0] scmd = sa[`PFA_A_CMD +: 4];

    // Command decode into one-hot operation
    reg [8:0] next_op;
    always @* begin
        next_op = 9'h000;
        case (scmd)
            `PFA_CMD_NONE: next_op = 9'h001;
            `PFA_CMD_SUB: next_op = 9'h002;
            `PFA_CMD_CF_MINUS_LATENCY_PLUS_PATH: next_op = 9'h004;
            `PFA_CMD_ADD: next_op = 9'h008;
            `PFA_CMD_SUB_ADD: next_op = 9'h010;
            `PFA_CMD_STORE: next_op = 9'h020;
            `PFA_CMD_LEGACY: next_op = 9'h040;
            `PFA_CMD_NS: next_op = 9'h080;
            `PFA_CMD_NS_PEER: next_op = 9'h100;
            default: next_op = 9'h001;
        endcase
    end

    wire [3:0] zcnt = sb[`PFA_B_ZERO_CNT +: 4];
    wire [2:0] fptr = sa[`PFA_A_FLAG_PTR +: 3];
    wire [8:0] pkt_sum = {1'b0, I_HDR_START} + {6'h00, fptr};

    // Action result, one cycle after the header strobe
    always @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_ACT_VALID <= 1'b0;
            O_ACT_HIT <= 1'b0;
            O_ACT_FLOW <= 3'h0;
            O_ACT_CMD <= 4'h0;
            O_ACT_OP <= 9'h000;
            O_SAVE_TIME <= 1'b0;
            O_CF_PTR <= 5'h00;
            O_TS_PTR <= 6'h00;
            O_ASYM_ADD <= 1'b0;
            O_ASYM_SUB <= 1'b0;
            O_ZERO_EN <= 1'b0;
            O_ZERO_PTR <= 6'h00;
            O_ZERO_CNT <= 4'h0;
            O_FLAG_PTR <= 3'h0;
            O_FLAG_PKT_OFS <= 8'h00;
            O_FLAG_UPD <= 1'b0;
            O_RW_BYTES <= 4'h0;
            O_RW_OFS <= 8'h00;
            O_NEW_CF_LOC <= 8'h00;
            last_flow <= 3'h0;
            last_hit <= 1'b0;
            hit_count <= 16'h0000;
        end else if (I_CE) begin
            O_ACT_VALID <= I_HDR_VALID;
            if (I_HDR_VALID) begin
                O_ACT_HIT <= any;
                O_ACT_FLOW <= sel;
                O_ACT_CMD <= any ? scmd : `PFA_CMD_NONE;
                O_ACT_OP <= any ? next_op : 9'h001;
                O_SAVE_TIME <= any && sa[`PFA_A_SAVE] && I_HDR_EGRESS;
                O_CF_PTR <= sa[`PFA_A_CF_PTR +: 5];
                O_TS_PTR <= sb[`PFA_B_TS_PTR +: 6];
                O_ASYM_ADD <= any && sa[`PFA_A_ASYM_ADD];
                O_ASYM_SUB <= any && sa[`PFA_A_ASYM_SUB];
                O_ZERO_EN <= any && (zcnt != 4'h0);
                O_ZERO_PTR <= sb[`PFA_B_ZERO_PTR +: 6];
                O_ZERO_CNT <= zcnt;
                O_FLAG_PTR <= fptr;
                O_FLAG_PKT_OFS <= pkt_sum[7:0];
                O_FLAG_UPD <= any && sa[`PFA_A_FLAG_UPD];
                O_RW_BYTES <= sb[`PFA_B_RW_BYTES +: 4];
                O_RW_OFS <= sc[`PFA_C_RW_OFS +: 8];
                O_NEW_CF_LOC <= sc[`PFA_C_NEW_CF +: 8];
                last_flow <= sel;
                last_hit <= any;
                if (any) begin
                    hit_count <= hit_count + 16'h0001;
                end
            end
        end
    end

    // Common selects toward checksum and signature logic
    always @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_CHKSUM_SEL <= 1'b0;
            O_ADDR_SRC <= 2'h0;
        end else if (I_CE) begin
            O_CHKSUM_SEL <= common[0];
            O_ADDR_SRC <= common[2:1];
        end
    end
endmodule

// ==== tb/pfa_checker.sv ====
// Port-level assertions for the flow action comparator
module pfa_checker (
    input logic I_MCLK,
    input logic I_RSTN,
    input logic I_CE,
    input logic I_PSEL,
    input logic I_PENABLE,
    input logic I_HDR_VALID,
    input logic I_HDR_EGRESS,
    input logic [7:0] I_HDR_START,
    input logic O_PREADY,
    input logic O_PSLVERR,
    input logic O_ACT_VALID,
    input logic O_ACT_HIT,
    input logic [3:0] O_ACT_CMD,
    input logic [8:0] O_ACT_OP,
    input logic O_SAVE_TIME,
    input logic O_ZERO_EN,
    input logic [3:0] O_ZERO_CNT,
    input logic [2:0] O_FLAG_PTR,
    input logic [7:0] O_FLAG_PKT_OFS
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);
    // Bus transfer steps
    sequence apb_setup;
        I_PSEL && !I_PENABLE && I_CE;
    endsequence
    sequence apb_access;
        I_PSEL && I_PENABLE && I_CE;
    endsequence
    AST_APB_WAIT: assert property (apb_setup ##1 apb_access |=> O_PREADY)
        else $error("ready missing after one wait state");
    AST_ERR_READY: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error flag without ready");
    AST_ACT_ANSWER: assert property (I_HDR_VALID && I_CE |=> O_ACT_VALID)
        else $error("no action result after header strobe");
    AST_ACT_PULSE: assert property (!I_HDR_VALID && I_CE |=> !O_ACT_VALID)
        else $error("action valid without header strobe");
    AST_ACT_HOLD: assert property (!I_HDR_VALID && I_CE |=> $stable(O_ACT_CMD) && $stable(O_ACT_HIT))
        else $error("action result changed between strobes");
    AST_MISS_NOP: assert property (O_ACT_VALID && !O_ACT_HIT |-> O_ACT_CMD == 4'h0 && O_ACT_OP == 9'h001)
        else $error("miss gave an action");
    AST_OP_DECODE: assert property (O_ACT_VALID && O_ACT_CMD < 4'h9 |-> O_ACT_OP == 9'h001 << O_ACT_CMD)
        else $error("operation select does not match command");
    AST_SAVE: assert property (O_SAVE_TIME |-> O_ACT_HIT && (!O_ACT_VALID || $past(I_HDR_EGRESS)))
        else $error("time save without hit on egress");
    AST_ZERO_EN: assert property (O_ZERO_EN == (O_ACT_HIT && O_ZERO_CNT != 4'h0))
        else $error("zeroing enable wrong");
    AST_FLAG_OFS: assert property (O_ACT_VALID |-> O_FLAG_PKT_OFS == $past(I_HDR_START) + O_FLAG_PTR)
        else $error("flag packet offset wrong");
endmodule

bind pfa_comparator pfa_checker u_chk (.I_MCLK, .I_RSTN, .I_CE, .I_PSEL, .I_PENABLE,
    .I_HDR_VALID, .I_HDR_EGRESS, .I_HDR_START, .O_PREADY, .O_PSLVERR, .O_ACT_VALID,
    .O_ACT_HIT, .O_ACT_CMD, .O_ACT_OP, .O_SAVE_TIME, .O_ZERO_EN, .O_ZERO_CNT,
    .O_FLAG_PTR, .O_FLAG_PKT_OFS);

// ==== tb/pfa_feed.sv ====
// Model of the earlier comparator stages presenting headers
module pfa_feed (
    input logic i_clk,
    output logic o_valid,
    output logic [255:0] o_bytes,
    output logic o_oam,
    output logic o_chan,
    output logic o_egress,
    output logic [1:0] o_group,
    output logic [7:0] o_start
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle values
    initial begin
        o_valid = 1'b0;
        o_bytes = '0;
        {o_oam, o_chan, o_egress, o_group} = '0;
        o_start = 8'hf8;
    end
    // One strobe; bytes turn over after it so stale data is never reused
    task automatic send(input logic [63:0] p, input logic [7:0] b9, input logic c,
        input logic o, input logic [1:0] g);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_bytes <= {p, 8'h00, b9, 176'h0};
        {o_chan, o_oam, o_group, o_egress} <= {c, o, g, 1'b1};
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_bytes <= ~{p, 8'h00, b9, 176'h0};
    endtask
endmodule

// ==== tb/pfa_comparator_bench.sv ====
// Self-checking bench for the flow action comparator
module pfa_comparator_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic I_MCLK, I_RSTN, I_CE, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR;
    logic [11:0] I_PADDR;
    logic [31:0] I_PWDATA, O_PRDATA, rd;
    logic I_HDR_VALID, I_HDR_OAM, I_HDR_CHAN, I_HDR_EGRESS, err;
    logic [255:0] I_HDR_BYTES;
    logic [1:0] I_PRIOR_GROUP, O_ADDR_SRC;
    logic [7:0] I_HDR_START, O_FLAG_PKT_OFS, O_RW_OFS, O_NEW_CF_LOC;
    logic O_ACT_VALID, O_ACT_HIT, O_SAVE_TIME, O_ASYM_ADD, O_ASYM_SUB, O_ZERO_EN;
    logic O_FLAG_UPD, O_CHKSUM_SEL;
    logic [2:0] O_ACT_FLOW, O_FLAG_PTR;
    logic [3:0] O_ACT_CMD, O_ZERO_CNT, O_RW_BYTES;
    logic [8:0] O_ACT_OP;
    logic [4:0] O_CF_PTR;
    logic [5:0] O_TS_PTR, O_ZERO_PTR;
    int fails = 0;
    int compares = 0;
    logic [63:0] pat = 64'h1122334455667788;
    logic [7:0] bnd [4] = '{8'h30, 8'h40, 8'h41, 8'h2f};

    pfa_comparator dut (.*);
    pfa_feed feed (.i_clk(I_MCLK), .o_valid(I_HDR_VALID), .o_bytes(I_HDR_BYTES),
        .o_oam(I_HDR_OAM), .o_chan(I_HDR_CHAN), .o_egress(I_HDR_EGRESS),
        .o_group(I_PRIOR_GROUP), .o_start(I_HDR_START));

    // Clock
    initial begin
        I_MCLK = 1'b0;
        forever #5 I_MCLK = ~I_MCLK;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus transfer, waiting on ready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge I_MCLK);
        {I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {2'b10, w, a, d};
        @(posedge I_MCLK);
        I_PENABLE <= 1'b1;
        do begin
            @(posedge I_MCLK);
            n++;
        end while (O_PREADY !== 1'b1 && n < 20);
        if (O_PREADY !== 1'b1) fails++;
        rd = O_PRDATA;
        err = O_PSLVERR;
        {I_PSEL, I_PENABLE} <= 2'b00;
    endtask

    // Header through the feed, then the decision of flow 1
    task automatic hdr(input logic [63:0] p, input logic [7:0] b9, input logic c,
        input logic o, input logic [1:0] g, input logic hit, input logic [3:0] cmd);
        feed.send(p, b9, c, o, g);
        #1;
        chk("valid", 1, O_ACT_VALID);
        chk("hit", hit, O_ACT_HIT);
        chk("cmd", hit ? cmd : 4'h0, O_ACT_CMD);
        chk("op", (hit && cmd < 9) ? 9'h001 << cmd : 9'h001, O_ACT_OP);
        if (hit) chk("flow", 1, O_ACT_FLOW);
    endtask

    task automatic give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #100000;
        fails++;
        give_verdict();
    end

    // Main sequence
    initial begin
        {I_RSTN, I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} = '0;
        I_CE = 1'b1;
        repeat (20) @(posedge I_MCLK);
        I_RSTN <= 1'b1;
        apb(0, 12'h02c, 0);
        chk("act reset", 0, rd);
        apb(0, 12'h200, 0);
        chk("unmapped err", 1, err);
        apb(1, 12'h02c, 32'hffffffff);
        apb(0, 12'h02c, 0);
        chk("act mask", 32'h071fffff, rd);
        apb(1, 12'h10c, 32'hffffffff);
        apb(0, 12'h10c, 0);
        chk("status ro", 0, rd);
        apb(1, 12'h100, 32'hffffffff);
        apb(1, 12'h104, 32'hffffffff);
        apb(1, 12'h020, pat[31:0]);
        apb(1, 12'h024, pat[63:32]);
        apb(1, 12'h030, 32'h0a031221);
        apb(1, 12'h034, 32'h00002e5c);
        for (int c = 0; c < 9; c++) begin
            apb(1, 12'h02c, 32'h030a0bb0 | c);
            hdr(pat, 0, 0, 0, 2'b01, 1, c);
        end
        chk("save", 1, O_SAVE_TIME);
        chk("cf ptr", 5'h0a, O_CF_PTR);
        chk("ts ptr", 6'h21, O_TS_PTR);
        chk("asym", 2'b10, {O_ASYM_ADD, O_ASYM_SUB});
        chk("zero", 11'h523, {O_ZERO_EN, O_ZERO_PTR, O_ZERO_CNT});
        chk("flag", 12'hbfb, {O_FLAG_UPD, O_FLAG_PTR, O_FLAG_PKT_OFS});
        chk("rw", 20'ha5c2e, {O_RW_BYTES, O_RW_OFS, O_NEW_CF_LOC});
        apb(0, 12'h10c, 0);
        chk("status", 32'h00090101, rd);
        hdr(pat ^ 64'h1, 0, 0, 0, 2'b01, 0, 8);
        apb(1, 12'h100, 32'hfffffffe);
        hdr(pat ^ 64'h1, 0, 0, 0, 2'b01, 1, 8);
        hdr(pat, 0, 1, 0, 2'b01, 0, 8);
        hdr(pat, 0, 0, 0, 2'b10, 0, 8);
        hdr(pat, 0, 0, 0, 2'b11, 1, 8);
        hdr(pat ^ 64'h100, 0, 0, 1, 2'b01, 1, 8);
        hdr(pat ^ 64'h100, 0, 0, 0, 2'b01, 0, 8);
        apb(1, 12'h028, 32'h01094030);
        for (int i = 0; i < 4; i++) begin
            hdr(pat, bnd[i], 0, 0, 2'b01, i < 2, 8);
        end
        apb(1, 12'h030, 32'h0a001221);
        hdr(pat, 8'h30, 0, 0, 2'b01, 1, 8);
        chk("zero off", 0, O_ZERO_EN);
        apb(1, 12'h02c, 32'h030a0ab8);
        hdr(pat, 8'h30, 0, 0, 2'b01, 0, 8);
        apb(1, 12'h108, 32'h5);
        @(posedge I_MCLK);
        #1;
        chk("common", 3'b110, {O_CHKSUM_SEL, O_ADDR_SRC});
        give_verdict();
    end
endmodule
